// ### rtl/csp_pkg.sv
package csp_pkg;
	// Command byte layout: gating bit, read flag, register address.
	localparam int        CMD_W        = 8;
	localparam int        CMD_RW_BIT   = 6;
	localparam int        CMD_ADDR_LSB = 3;
	localparam int        ADDR_W       = 3;
	localparam int        DATA_W       = 24;
	localparam int        CNT_W        = 6;
	localparam int        SYNC_STAGES  = 2;
	// Consecutive ones on the data input that reset the interface.
	localparam logic [5:0] ONES_RESET  = 6'h28;
	// Register addresses and transfer lengths in serial clocks.
	localparam logic [2:0] ADDR_COMM   = 3'h0;
	localparam logic [2:0] ADDR_ID     = 3'h4;
	localparam logic [2:0] ADDR_DATA   = 3'h3;
	localparam logic [2:0] ADDR_HALF   = 3'h6;
	localparam logic [5:0] LEN_BYTE    = 6'h08;
	localparam logic [5:0] LEN_HALF    = 6'h10;
	localparam logic [5:0] LEN_WORD    = 6'h18;
	localparam logic [5:0] LEN_CMD_TAIL = 6'h07;
	localparam logic [DATA_W-1:0] DATA_RST = 24'h000000;

	typedef enum logic [3:0] {
		ST_GATE  = 4'b0001,
		ST_CMD   = 4'b0010,
		ST_WRITE = 4'b0100,
		ST_READ  = 4'b1000
	} csp_state_t;

	typedef struct packed {
		logic              valid;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} csp_wr_t;

	function automatic logic [5:0] reg_len(input logic [2:0] addr);
		if (addr == ADDR_COMM || addr == ADDR_ID) begin
			return LEN_BYTE;
		end
		if (addr == ADDR_HALF) begin
			return LEN_HALF;
		end
		return LEN_WORD;
	endfunction
endpackage

// ### rtl/csp_sync.sv
`timescale 1ns/1ps
module csp_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_q;

	// Both stages reset high so an idle bus is seen until real samples land.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			meta_q <= '1;
			q      <= '1;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule

// ### rtl/csp_fsm.sv
`timescale 1ns/1ps
// Function
// - Transfer ends after register's known bit count
// - Sixteen-bit class writes capture one bit per clock
// - Every finished transfer returns to command wait
// - Command write opens with a zero gating bit
// - A one at gating position is discarded
// - Zero gate loads next seven command bits
// - Writes via data input, reads via output
// - Output line goes low when result ready
// - Output returns high after data read ends
// - Line rises before data register update
// - Chip select enables this device on shared bus
// - Forty ones reset interface and registers
// - Chip select high ignores all bus activity
module csp_fsm #(
	parameter int DATA_W = csp_pkg::DATA_W
) (
	// Clock and reset.
	input  wire logic                       CLK,
	input  wire logic                       RESET,
	// Serial pins from the host.
	input  wire logic                       CS_N,
	input  wire logic                       SCLK,
	input  wire logic                       DIN,
	// Combined data-out and ready pin.
	output logic                            DOUT_O,
	output logic                            DOUT_OE,
	// Converter core side.
	input  wire logic                       RESULT_PENDING,
	input  wire logic                       RESULT_VALID,
	input  wire logic [DATA_W-1:0]          RESULT_DATA,
	// On-chip register access.
	output logic [csp_pkg::ADDR_W-1:0]      RD_ADDR,
	input  wire logic [DATA_W-1:0]          RD_DATA,
	output csp_pkg::csp_wr_t                WR_REQ,
	output logic                            REGS_RESET
);
	// Refuse a width that the package types and lengths cannot serve.
	if (DATA_W != csp_pkg::DATA_W) begin : g_width_check
		$error("DATA_W must match the package data width.");
	end

	logic [2:0]              pins_s;
	logic                    cs_n_s;
	logic                    sclk_s;
	logic                    din_s;
	logic                    sclk_prev_q;
	logic                    rise;
	logic                    fall;
	csp_pkg::csp_state_t     state_q;
	logic [5:0]              cnt_q;
	logic [5:0]              len_q;
	logic [6:0]              cmd_q;
	logic [DATA_W-1:0]       shift_q;
	logic [DATA_W-1:0]       result_q;
	logic                    load_q;
	logic                    is_data_q;
	logic                    rdy_n_q;
	logic [5:0]              ones_q;
	logic                    ones_hit;
	logic                    last_bit;
	logic                    read_done;

	// Pins cross into the clock domain before anything looks at them.
	csp_sync #(.WIDTH(3)) u_sync (
		.clk   (CLK),
		.reset (RESET),
		.d     ({CS_N, SCLK, DIN}),
		.q     (pins_s)
	);
	assign cs_n_s = pins_s[2];
	assign sclk_s = pins_s[1];
	assign din_s  = pins_s[0];

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			sclk_prev_q <= 1'b1;
		end else begin
			sclk_prev_q <= sclk_s;
		end
	end

	// Edges count only while selected; a deselected device is deaf.
	assign rise = ~cs_n_s & sclk_s & ~sclk_prev_q;
	assign fall = ~cs_n_s & ~sclk_s & sclk_prev_q;

	assign last_bit  = (cnt_q + 6'h01 == len_q);
	assign ones_hit  = rise & din_s & (ones_q == csp_pkg::ONES_RESET - 6'h01);
	assign read_done = rise & (state_q == csp_pkg::ST_READ) & last_bit;

	// Run of consecutive ones seen on the data input.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			ones_q <= 6'h00;
		end else if (rise) begin
			ones_q <= (din_s && !ones_hit) ? ones_q + 6'h01 : 6'h00;
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			REGS_RESET <= 1'b0;
		end else begin
			REGS_RESET <= ones_hit;
		end
	end

	// Transfer sequencer.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			state_q   <= csp_pkg::ST_GATE;
			cnt_q     <= 6'h00;
			len_q     <= csp_pkg::LEN_CMD_TAIL;
			cmd_q     <= 7'h00;
			is_data_q <= 1'b0;
			RD_ADDR   <= '0;
		end else if (ones_hit) begin
			state_q <= csp_pkg::ST_GATE;
			cnt_q   <= 6'h00;
		end else if (rise) begin
			unique case (state_q)
				csp_pkg::ST_GATE: begin
					// A one here leaves us parked on the gate position.
					if (!din_s) begin
						state_q <= csp_pkg::ST_CMD;
						cnt_q   <= 6'h00;
						len_q   <= csp_pkg::LEN_CMD_TAIL;
					end
				end
				csp_pkg::ST_CMD: begin
					cmd_q <= {cmd_q[5:0], din_s};
					cnt_q <= cnt_q + 6'h01;
					if (last_bit) begin
						RD_ADDR   <= cmd_q[4:2];
						len_q     <= csp_pkg::reg_len(cmd_q[4:2]);
						is_data_q <= (cmd_q[4:2] == csp_pkg::ADDR_DATA);
						cnt_q     <= 6'h00;
						state_q   <= cmd_q[5] ? csp_pkg::ST_READ
						                      : csp_pkg::ST_WRITE;
					end
				end
				csp_pkg::ST_WRITE, csp_pkg::ST_READ: begin
					cnt_q <= cnt_q + 6'h01;
					if (last_bit) begin
						state_q <= csp_pkg::ST_GATE;
						cnt_q   <= 6'h00;
					end
				end
			endcase
		end
	end

	// One-cycle flag to fetch read data after the address has settled.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			load_q <= 1'b0;
		end else begin
			load_q <= rise & (state_q == csp_pkg::ST_CMD) & last_bit
			          & cmd_q[5];
		end
	end

	// Shift register: captures writes on rising edges, feeds reads.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			shift_q <= '0;
		end else if (load_q) begin
			// Left-align so the register's MSB leaves first.
			shift_q <= (is_data_q ? result_q : RD_DATA)
			           << (6'(DATA_W) - len_q);
		end else if (rise && state_q == csp_pkg::ST_GATE && !din_s) begin
			// Leftover bits would otherwise sit above a short write.
			shift_q <= '0;
		end else if (rise && state_q == csp_pkg::ST_WRITE) begin
			shift_q <= {shift_q[DATA_W-2:0], din_s};
		end else if (fall && state_q == csp_pkg::ST_READ) begin
			shift_q <= {shift_q[DATA_W-2:0], 1'b0};
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			WR_REQ <= '0;
		end else begin
			WR_REQ.valid <= rise & (state_q == csp_pkg::ST_WRITE) & last_bit;
			if (rise && state_q == csp_pkg::ST_WRITE && last_bit) begin
				WR_REQ.addr <= RD_ADDR;
				WR_REQ.data <= {shift_q[DATA_W-2:0], din_s};
			end
		end
	end

	// Result register reloads to its default on the forty-ones reset.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			result_q <= csp_pkg::DATA_RST;
		end else if (ones_hit) begin
			result_q <= csp_pkg::DATA_RST;
		end else if (RESULT_VALID) begin
			result_q <= RESULT_DATA;
		end
	end

	// Ready flag, active low. The core raises it before an update.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			rdy_n_q <= 1'b1;
		end else if (RESULT_PENDING || ones_hit) begin
			rdy_n_q <= 1'b1;
		end else if (RESULT_VALID) begin
			rdy_n_q <= 1'b0;
		end else if (read_done && is_data_q) begin
			rdy_n_q <= 1'b1;
		end
	end

	// Pin driver: data during a read, otherwise the ready flag.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			DOUT_O  <= 1'b1;
			DOUT_OE <= 1'b0;
		end else begin
			DOUT_OE <= ~cs_n_s;
			if (state_q != csp_pkg::ST_READ) begin
				DOUT_O <= rdy_n_q;
			end else if (fall) begin
				DOUT_O <= shift_q[DATA_W-1];
			end
		end
	end
endmodule

// ### dv/csp_fsm_chk.sv
`timescale 1ns/1ps
module csp_fsm_chk #(
	parameter int DATA_W = csp_pkg::DATA_W
) (
	// Clock, reset and pins.
	input wire logic                  CLK,
	input wire logic                  RESET,
	input wire logic                  CS_N,
	input wire logic                  SCLK,
	input wire logic                  DIN,
	input wire logic                  DOUT_O,
	input wire logic                  DOUT_OE,
	// Core and register side.
	input wire logic                  RESULT_PENDING,
	input wire logic                  RESULT_VALID,
	input wire logic [DATA_W-1:0]     RESULT_DATA,
	input wire logic [2:0]            RD_ADDR,
	input wire logic [DATA_W-1:0]     RD_DATA,
	input wire csp_pkg::csp_wr_t      WR_REQ,
	input wire logic                  REGS_RESET
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	a_oe_off_desel: assert property (
		CS_N [*4] |=> !DOUT_OE)
		else $error("pin driven while deselected");
	a_oe_on_sel: assert property (
		!CS_N [*4] |=> DOUT_OE)
		else $error("pin not driven while selected");
	a_wr_single: assert property (
		WR_REQ.valid |=> !WR_REQ.valid [*8])
		else $error("write request longer than one cycle");
	a_wr_addr_match: assert property (
		WR_REQ.valid |-> WR_REQ.addr == RD_ADDR)
		else $error("write address differs from transfer address");
	a_clr_single: assert property (
		REGS_RESET |=> !REGS_RESET [*8])
		else $error("register clear pulse too long");
	a_clr_ready: assert property (
		REGS_RESET |=> ##[0:2] DOUT_O)
		else $error("ready not high after interface reset");
	a_new_ready_low: assert property (
		RESULT_VALID && !RESULT_PENDING |=> ##[0:2] !DOUT_O)
		else $error("ready not low after new result");
	a_out_rise_quiet: assert property (
		(SCLK && !RESULT_VALID && !RESULT_PENDING) [*8]
		|-> $stable(DOUT_O))
		else $error("output moved while serial clock high");
endmodule

// ### dv/csp_host.sv
`timescale 1ns/1ps
module csp_host (
	// Bench clock.
	input  wire logic clk,
	// Serial pins.
	output logic      cs_n,
	output logic      sclk,
	output logic      din,
	input  wire logic dout
);
	// Data idles high so a stray clock only ever sees a discarded gate.
	initial begin
		cs_n = 1'b0;
		sclk = 1'b1;
		din  = 1'b1;
	end
	// The bench steers the select line only through this task.
	task automatic set_cs_n(input logic level);
		cs_n = level;
	endtask
	task automatic xfer(input logic [39:0] tx, input int n,
		output logic [31:0] rx);
		rx = '0;
		for (int i = n - 1; i >= 0; i--) begin
			repeat (8) @(negedge clk);
			sclk = 1'b0;
			din  = tx[i];
			repeat (8) @(negedge clk);
			rx   = {rx[30:0], dout};
			sclk = 1'b1;
		end
		repeat (8) @(negedge clk);
		din = 1'b1;
	endtask
endmodule

// ### dv/converter_serial_port_fsm_tb_top.sv
`timescale 1ns/1ps
module converter_serial_port_fsm_tb_top;
	logic                 clk, reset, cs_n, sclk, din, dout_o, dout_oe;
	logic                 res_pend, res_valid, regs_reset, dout_pin;
	logic [23:0]          res_data, rd_data, d;
	logic [2:0]           rd_addr;
	logic [31:0]          rx;
	csp_pkg::csp_wr_t     wr_req, wr_last;
	int                   miscompares, tests_run, wr_n, clr_n, len;
	// The pin has a pull-up here, so a released line reads high.
	assign dout_pin = dout_oe ? dout_o : 1'b1;
	assign rd_data  = {3{rd_addr, 5'h0b}};
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (wr_req.valid === 1'b1) begin
			wr_n++;
			wr_last = wr_req;
		end
		if (regs_reset === 1'b1) clr_n++;
	end
	csp_fsm uut (.CLK(clk), .RESET(reset), .CS_N(cs_n), .SCLK(sclk),
		.DIN(din), .DOUT_O(dout_o), .DOUT_OE(dout_oe),
		.RESULT_PENDING(res_pend), .RESULT_VALID(res_valid),
		.RESULT_DATA(res_data), .RD_ADDR(rd_addr), .RD_DATA(rd_data),
		.WR_REQ(wr_req), .REGS_RESET(regs_reset));
	csp_host u_host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .din(din),
		.dout(dout_pin));
	function automatic int blen(input int a);
		return (a == 0 || a == 4) ? 8 : (a == 6) ? 16 : 24;
	endfunction
	function automatic logic [7:0] cmd(input int a, input logic rd);
		return {1'b0, rd, 3'(a), 3'h0};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic core(input logic v, input logic [23:0] r);
		@(negedge clk);
		res_data  = r;
		res_valid = v;
		res_pend  = ~v;
		@(negedge clk);
		res_valid = 1'b0;
		res_pend  = 1'b0;
		repeat (4) @(negedge clk);
	endtask
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		#400us;
		miscompares++;
		end_of_test;
	end
	initial begin
		miscompares = 0;
		tests_run = 0;
		wr_n = 0;
		clr_n = 0;
		reset = 1'b1;
		res_pend = 1'b0;
		res_valid = 1'b0;
		res_data = '0;
		repeat (8) @(posedge clk);
		@(negedge clk) reset = 1'b0;
		void'($urandom(83));
		for (int a = 0; a < 8; a++) begin
			len = blen(a);
			d = (a == 5) ? 24'hffffff : 24'($urandom()) >> (24 - len);
			if (a == 2) u_host.xfer(40'h7, 3, rx);
			u_host.xfer((40'(cmd(a, 1'b0)) << len) | d, 8 + len,
				rx);
			repeat (4) @(negedge clk);
			chk(wr_n, a + 1);
			chk({wr_last.addr, wr_last.data}, {3'(a), d});
		end
		$display("write test done");
		for (int a = 0; a < 8; a++) begin
			if (a == 3) continue;
			u_host.xfer(40'(cmd(a, 1'b1)), 8, rx);
			u_host.xfer('0, blen(a), rx);
			// Short registers hand back the low bits of the read word.
			chk(rx, {3{a[2:0], 5'h0b}} >> (24 - blen(a)));
		end
		$display("register read test done");
		core(1'b1, 24'h5a5a5a);
		chk(dout_pin, 1'b0);
		core(1'b0, '0);
		chk(dout_pin, 1'b1);
		d = 24'($urandom());
		core(1'b1, d);
		// A data read may only start once the ready line is low.
		chk(dout_pin, 1'b0);
		u_host.xfer(40'(cmd(3, 1'b1)), 8, rx);
		u_host.xfer('0, 24, rx);
		chk(rx, d);
		chk(dout_pin, 1'b1);
		$display("result read test done");
		@(negedge clk);
		u_host.set_cs_n(1'b1);
		// A full write frame, so a deaf device is the only way to pass.
		u_host.xfer({cmd(1, 1'b0), 24'h00003c}, 32, rx);
		chk(wr_n, 8);
		chk(dout_oe, 1'b0);
		@(negedge clk);
		u_host.set_cs_n(1'b0);
		core(1'b1, 24'h123456);
		chk(clr_n, 0);
		u_host.xfer(40'hffffffffff, 40, rx);
		repeat (4) @(negedge clk);
		chk(clr_n, 1);
		chk(dout_pin, 1'b1);
		$display("select and clear test done");
		end_of_test;
	end
endmodule
bind csp_fsm csp_fsm_chk #(.DATA_W(DATA_W)) u_chk (.CLK(CLK), .RESET(RESET),
	.CS_N(CS_N), .SCLK(SCLK), .DIN(DIN), .DOUT_O(DOUT_O), .DOUT_OE(DOUT_OE),
	.RESULT_PENDING(RESULT_PENDING), .RESULT_VALID(RESULT_VALID),
	.RESULT_DATA(RESULT_DATA), .RD_ADDR(RD_ADDR), .RD_DATA(RD_DATA),
	.WR_REQ(WR_REQ), .REGS_RESET(REGS_RESET));
